// >>> hdl/tc_readout_pkg.sv
// constants, register map and state encoding of the thermocouple serial readout
package tc_readout_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_HZ        = 40_000_000;                    // pclk rate
	localparam int MS_PER_S      = 1000;                          // unit conversion
	localparam int CONV_TIME_MS  = 100;                           // one conversion period
	localparam int CONV_CYCLES   = CLK_HZ / MS_PER_S * CONV_TIME_MS; // longest time, rounds down
	localparam int CONV_CNT_W    = 32;                            // conversion counter width

	////////////////////////////////////////////////////////////////////////////////
	// serial frame layout
	localparam int FRAME_BITS    = 32;                            // bits in a full frame
	localparam int CNT_W         = 6;                             // bit counter width
	localparam int TC_W          = 14;                            // thermocouple field width
	localparam int REF_W         = 12;                            // reference field width
	localparam int FAULT_W       = 3;                             // fault flag count
	localparam int TC_MSB        = 31;                            // thermocouple sign bit
	localparam int TC_LSB        = 18;                            // thermocouple lsb
	localparam int REF_MSB       = 15;                            // reference sign bit
	localparam int REF_LSB       = 4;                             // reference lsb
	localparam int SUPPLY_BIT    = 2;                             // short to supply
	localparam int GROUND_BIT    = 1;                             // short to ground
	localparam int OPEN_BIT      = 0;                             // open connection
	localparam logic [CNT_W-1:0] LAST_CNT = 6'h1f;                // count before the 32nd edge
	localparam logic [CNT_W-1:0] FULL_CNT = 6'h20;                // full frame count

	////////////////////////////////////////////////////////////////////////////////
	// apb register map (byte addresses)
	localparam int ADDR_W        = 8;                             // decoded address width
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;           // control
	localparam logic [ADDR_W-1:0] OFS_TC_DATA  = 8'h04;           // staged thermocouple value
	localparam logic [ADDR_W-1:0] OFS_REF_DATA = 8'h08;           // staged reference value
	localparam logic [ADDR_W-1:0] OFS_FAULT    = 8'h0c;           // staged fault flags
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;           // link status
	localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h14;           // sticky events, w1c
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h18;           // interrupt mask
	localparam logic [ADDR_W-1:0] OFS_LIVE     = 8'h1c;           // frame word on offer
	localparam int CTRL_EN_BIT   = 0;                             // conversion enable
	localparam int STAT_ACT_BIT  = 0;                             // frame in progress
	localparam int STAT_PEND_BIT = 1;                             // update waiting for select high
	localparam int STAT_CNT_LSB  = 8;                             // bit count field
	localparam int INT_W         = 3;                             // event count
	localparam int INT_DONE      = 0;                             // full frame read
	localparam int INT_ABORT     = 1;                             // frame cut short
	localparam int INT_UPD       = 2;                             // frame data refreshed

	////////////////////////////////////////////////////////////////////////////////
	// link state machine
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,                                        // select high
		ST_SHIFT = 3'b010,                                        // bits going out
		ST_DONE  = 3'b100                                         // all 32 bits sent
	} link_state_t;

endpackage

// >>> hdl/tc_pin_sync.sv
// two-stage synchroniser for pins arriving from outside the pclk domain
module tc_pin_sync #(
	parameter int                WIDTH     = 2,          // number of pins
	parameter logic [WIDTH-1:0]  RESET_VAL = '0          // idle level of the pins
) (
	input  wire logic             pclk,                 // system clock
	input  wire logic             presetn,              // async reset, active low
	input  wire logic [WIDTH-1:0] pin_in,               // raw pins
	output logic      [WIDTH-1:0] pin_sync              // synchronised levels
);

	logic [WIDTH-1:0] meta_ff;                           // first stage, read only by stage two
	logic [WIDTH-1:0] sync_ff;                           // second stage

	////////////////////////////////////////////////////////////////////////////////
	// one generate loop, two flops per pin
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meta_ff[i] <= RESET_VAL[i];
				sync_ff[i] <= RESET_VAL[i];
			end else begin
				meta_ff[i] <= pin_in[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign pin_sync = sync_ff;

endmodule

// >>> hdl/tc_readout.sv
// serial readout port of a thermocouple converter with apb staging registers
// Operation
// (R1) full frame is 32 clocks, all fields
// (R2) host pulls select low, then clocks
// (R3) select fall puts sign bit out
// (R4) msb first, change on falling clock
// (R5) host may raise select early
// (R6) data refresh only while select high
// (R7) 14 clocks give thermocouple value only
// (R8) bits 31..18 thermocouple, quarter degree
// (R9) bits 15..4 reference, sixteenth degree
// (R10) bits 2,1,0 supply, ground, open faults
// (R11) thermocouple field two's complement quarters
// (R12) reference field two's complement sixteenths
// (R13) host waits 200 ms after power
// (R14) one conversion per 100 ms
// (R15) output only, no host data in
// (R16) data line released while select high
module tc_readout
	import tc_readout_pkg::*;
#(
	parameter int CONV_PERIOD = tc_readout_pkg::CONV_CYCLES       // pclk cycles per conversion
) (
	input  wire logic                             pclk,          // system clock
	input  wire logic                             presetn,       // async reset, active low
	input  wire logic [tc_readout_pkg::ADDR_W-1:0] paddr,        // apb address
	input  wire logic                             psel,          // apb select
	input  wire logic                             penable,       // apb enable
	input  wire logic                             pwrite,        // apb direction
	input  wire logic [31:0]                      pwdata,        // apb write data
	output logic                                  pready,        // apb ready
	output logic      [31:0]                      prdata,        // apb read data
	output logic                                  pslverr,       // apb error
	input  wire logic                             sclk,          // serial clock pin
	input  wire logic                             cs_n,          // select pin, active low
	output logic                                  sdo,           // serial data out
	output logic                                  sdo_oe,        // serial data drive enable
	output logic                                  irq            // level interrupt
);

	import tc_readout_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [1:0]            pins_sync;            // {cs_n, sclk} after two flops
	logic                  sclk_s;               // synced serial clock
	logic                  cs_act;               // synced select active
	logic                  sclk_d_ff;            // previous sclk level
	logic                  cs_act_d_ff;          // previous select level
	logic                  sclk_rise;            // host samples here
	logic                  sclk_fall;            // device shifts here
	logic                  cs_fall;              // frame start
	logic                  cs_rise;              // frame end
	link_state_t           state_ff;             // link state
	link_state_t           nxt_state;            // next link state
	logic [CNT_W-1:0]      bit_cnt_ff;           // rising edges seen in frame
	logic [FRAME_BITS-1:0] shift_ff;             // outgoing frame
	logic                  sdo_ff;               // data pin register
	logic                  sdo_oe_ff;            // drive enable register
	logic                  ctrl_en_ff;           // conversion enable
	logic [TC_W-1:0]       tc_stage_ff;          // staged thermocouple value
	logic [REF_W-1:0]      ref_stage_ff;         // staged reference value
	logic [FAULT_W-1:0]    fault_stage_ff;       // staged fault flags
	logic [TC_W-1:0]       tc_live_ff;           // thermocouple value on offer
	logic [REF_W-1:0]      ref_live_ff;          // reference value on offer
	logic [FAULT_W-1:0]    fault_live_ff;        // fault flags on offer
	logic [CONV_CNT_W-1:0] conv_cnt_ff;          // conversion period counter
	logic                  conv_wrap;            // end of a conversion period
	logic                  conv_due_ff;          // fresh data waiting
	logic                  upd_go;               // copy stage into live now
	logic [FRAME_BITS-1:0] frame_word;           // assembled frame
	logic [INT_W-1:0]      int_stat_ff;          // sticky events
	logic [INT_W-1:0]      int_mask_ff;          // interrupt mask
	logic [INT_W-1:0]      int_evt;              // events this cycle
	logic                  frame_done;           // 32nd rising edge
	logic                  frame_abort;          // select rose early
	logic                  apb_wr;               // write takes effect
	logic                  apb_setup;            // setup phase
	logic                  addr_hit;             // address is mapped
	logic [31:0]           rd_mux;               // read data selection
	logic [31:0]           prdata_ff;            // registered read data
	logic [31:0]           status_word;          // status register view

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, both pins pass two flops before any logic
	tc_pin_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'b10)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   ({cs_n, sclk}),
		.pin_sync (pins_sync)
	);

	assign sclk_s = pins_sync[0];
	assign cs_act = ~pins_sync[1];

	// edge history of the synced pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d_ff   <= 1'b0;
			cs_act_d_ff <= 1'b0;
		end else begin
			sclk_d_ff   <= sclk_s;
			cs_act_d_ff <= cs_act;
		end
	end

	// edge decode
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign cs_fall   = cs_act & ~cs_act_d_ff;     // R2
	assign cs_rise   = ~cs_act & cs_act_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// frame assembly; reserved bits 17, 16 and 3 send zero
	// fields pass straight through as two's complement codes
	assign frame_word = {tc_live_ff,                          // R8 R11
	                     2'b00,
	                     ref_live_ff,                         // R9 R12
	                     1'b0,
	                     fault_live_ff};                      // R10

	////////////////////////////////////////////////////////////////////////////////
	// link state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cs_fall) begin
					nxt_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (!cs_act) begin
					nxt_state = ST_IDLE;                  // R5
				end else if (sclk_rise && bit_cnt_ff == LAST_CNT) begin
					nxt_state = ST_DONE;                  // R1
				end
			end
			ST_DONE: begin
				if (!cs_act) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// frame events; a partial read of 14 bits ends as an abort
	assign frame_done  = (state_ff == ST_SHIFT) && cs_act && sclk_rise
	                     && bit_cnt_ff == LAST_CNT;            // R1
	assign frame_abort = (state_ff == ST_SHIFT) && !cs_act;    // R5 R7

	// rising-edge counter, cleared at each frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_ff <= '0;
		end else if (cs_fall) begin
			bit_cnt_ff <= '0;
		end else if (state_ff == ST_SHIFT && sclk_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shifter: sign bit at select fall, next bit at each falling clock
	// the pin is only an output; nothing is sampled from the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_ff  <= '0;
			sdo_ff    <= 1'b0;
			sdo_oe_ff <= 1'b0;
		end else if (cs_fall) begin
			shift_ff  <= frame_word;                          // R3
			sdo_ff    <= frame_word[FRAME_BITS-1];            // R3
			sdo_oe_ff <= 1'b1;
		end else if (!cs_act) begin
			sdo_ff    <= 1'b0;
			sdo_oe_ff <= 1'b0;                                // R16
		end else if (sclk_fall) begin
			shift_ff  <= {shift_ff[FRAME_BITS-2:0], 1'b0};    // R4
			sdo_ff    <= shift_ff[FRAME_BITS-2];              // R4 R15
		end
	end

	assign sdo    = sdo_ff;
	assign sdo_oe = sdo_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// conversion timer; fresh data is offered once per period at most
	assign conv_wrap = ctrl_en_ff
	                   && conv_cnt_ff == CONV_CNT_W'(CONV_PERIOD - 1);  // R14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_cnt_ff <= '0;
		end else if (!ctrl_en_ff || conv_wrap) begin
			conv_cnt_ff <= '0;
		end else begin
			conv_cnt_ff <= conv_cnt_ff + 32'h1;
		end
	end

	// a finished conversion waits while select is low
	assign upd_go = conv_due_ff && !cs_act && !cs_act_d_ff;     // R6

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_due_ff <= 1'b0;
		end else if (conv_wrap) begin
			conv_due_ff <= 1'b1;                              // R14
		end else if (upd_go) begin
			conv_due_ff <= 1'b0;
		end
	end

	// live data, refreshed only with select high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_live_ff    <= '0;
			ref_live_ff   <= '0;
			fault_live_ff <= '0;
		end else if (upd_go) begin
			tc_live_ff    <= tc_stage_ff;                     // R6
			ref_live_ff   <= ref_stage_ff;
			fault_live_ff <= fault_stage_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign addr_hit  = paddr == OFS_CTRL || paddr == OFS_TC_DATA
	                   || paddr == OFS_REF_DATA || paddr == OFS_FAULT
	                   || paddr == OFS_STATUS || paddr == OFS_INT_STAT
	                   || paddr == OFS_INT_MASK || paddr == OFS_LIVE;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~addr_hit;

	// status view: active, pending update, bit count
	assign status_word = {18'h0, bit_cnt_ff, 6'h0, conv_due_ff, cs_act};

	// read selection
	assign rd_mux = (paddr == OFS_CTRL)     ? {31'h0, ctrl_en_ff} :
	                (paddr == OFS_TC_DATA)  ? {18'h0, tc_stage_ff} :
	                (paddr == OFS_REF_DATA) ? {20'h0, ref_stage_ff} :
	                (paddr == OFS_FAULT)    ? {29'h0, fault_stage_ff} :
	                (paddr == OFS_STATUS)   ? status_word :
	                (paddr == OFS_INT_STAT) ? {29'h0, int_stat_ff} :
	                (paddr == OFS_INT_MASK) ? {29'h0, int_mask_ff} :
	                (paddr == OFS_LIVE)     ? frame_word : 32'h0;

	// read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (apb_setup) begin
			prdata_ff <= rd_mux;
		end
	end

	assign prdata = prdata_ff;

	// writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_ff     <= 1'b0;
			tc_stage_ff    <= '0;
			ref_stage_ff   <= '0;
			fault_stage_ff <= '0;
			int_mask_ff    <= '0;
		end else if (apb_wr) begin
			case (paddr)
				OFS_CTRL:     ctrl_en_ff     <= pwdata[CTRL_EN_BIT];
				OFS_TC_DATA:  tc_stage_ff    <= pwdata[TC_W-1:0];
				OFS_REF_DATA: ref_stage_ff   <= pwdata[REF_W-1:0];
				OFS_FAULT:    fault_stage_ff <= pwdata[FAULT_W-1:0];
				OFS_INT_MASK: int_mask_ff    <= pwdata[INT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, a new event wins over the clear
	assign int_evt[INT_DONE]  = frame_done;
	assign int_evt[INT_ABORT] = frame_abort;
	assign int_evt[INT_UPD]   = upd_go;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_ff <= '0;
		end else if (apb_wr && paddr == OFS_INT_STAT) begin
			int_stat_ff <= (int_stat_ff & ~pwdata[INT_W-1:0]) | int_evt;
		end else begin
			int_stat_ff <= int_stat_ff | int_evt;
		end
	end

	assign irq = |(int_stat_ff & int_mask_ff);

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_frame_start;
		cs_fall;
	endsequence

	sequence s_update;
		upd_go;
	endsequence

	AST_RELEASE_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // R16
		!cs_act && !cs_fall |=> !sdo_oe)
		else $error("data line driven with select high");

	AST_SIGN_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // R3
		s_frame_start |=> sdo == $past(tc_live_ff[TC_W-1]) && sdo_oe)
		else $error("sign bit not presented at select fall");

	AST_SHIFT_MSB: assert property (@(posedge pclk) disable iff (!presetn) // R4
		cs_act && sclk_fall && !cs_fall |=> sdo == $past(shift_ff[FRAME_BITS-2]))
		else $error("wrong bit after falling clock");

	AST_HOLD_IN_FRAME: assert property (@(posedge pclk) disable iff (!presetn) // R6
		cs_act |=> $stable(tc_live_ff) && $stable(ref_live_ff) && $stable(fault_live_ff))
		else $error("frame data changed while selected");

	AST_DONE_AT_32: assert property (@(posedge pclk) disable iff (!presetn) // R1
		state_ff == ST_SHIFT && cs_act && sclk_rise && bit_cnt_ff == LAST_CNT
		|=> int_stat_ff[INT_DONE] && bit_cnt_ff == FULL_CNT && state_ff == ST_DONE)
		else $error("frame end not flagged at 32 bits");

	AST_TC_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // R8
		s_update |=> frame_word[TC_MSB:TC_LSB] == $past(tc_stage_ff))
		else $error("thermocouple field not refreshed");

	AST_REF_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // R9
		s_update |=> frame_word[REF_MSB:REF_LSB] == $past(ref_stage_ff))
		else $error("reference field not refreshed");

	AST_FAULT_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // R10
		s_update |=> frame_word[SUPPLY_BIT] == $past(fault_stage_ff[SUPPLY_BIT])
		&& frame_word[GROUND_BIT] == $past(fault_stage_ff[GROUND_BIT])
		&& frame_word[OPEN_BIT] == $past(fault_stage_ff[OPEN_BIT]))
		else $error("fault flags not refreshed");

	AST_CONV_DUE: assert property (@(posedge pclk) disable iff (!presetn) // R14
		conv_wrap |=> conv_due_ff && conv_cnt_ff == '0)
		else $error("conversion period end lost");

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		int_evt[INT_ABORT] && int_mask_ff[INT_ABORT] && !apb_wr |=> irq)
		else $error("masked-in event did not raise interrupt");

endmodule

// >>> bench/tc_host_model.sv
// host controller model: drives select and serial clock, samples the data line
module tc_host_model (
	input  wire logic pclk,      // system clock, pacing of the link clock
	output logic      sclk,      // serial clock, idles low between frames
	output logic      cs_n,      // select, active low
	input  wire logic sdo_line   // resolved serial data line
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle levels at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	// one read of n bits, 200 ns link period; the data line is the only wire in
	task automatic read_frame(input int n, output logic [31:0] w);
		w = '0;
		@(posedge pclk);
		cs_n <= 1'b0;
		repeat (8) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			sclk <= 1'b1;
			@(posedge pclk);
			w = {w[30:0], sdo_line};
			repeat (3) @(posedge pclk);
			sclk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// >>> bench/thermocouple_spi_readout_tb_top.sv
// self-checking bench of the thermocouple serial readout
module thermocouple_spi_readout_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tc_readout_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        sclk, cs_n, sdo, sdo_oe, irq, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	int          err_count = 0;
	int          n_tests = 0;
	logic        last_sdo = 1'b0;                    // last driven bit
	wire         sdo_line = sdo_oe ? sdo : ~last_sdo; // released line shows no stale bit

	always @(posedge pclk) if (sdo_oe) last_sdo <= sdo;

	tc_readout #(.CONV_PERIOD(50)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
		.sdo_oe(sdo_oe), .irq(irq));
	tc_host_model host_u (.pclk(pclk), .sclk(sclk), .cs_n(cs_n), .sdo_line(sdo_line));

	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, bus and closing tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected frame word
	function automatic logic [31:0] fexp(logic [13:0] t, logic [11:0] c, logic [2:0] f);
		return {t, 2'b00, c, 1'b0, f};
	endfunction

	// poll the event register until the given bit is set
	task automatic wait_stat(input int b);
		logic [31:0] r = '0;
		for (int i = 0; i < 40 && !r[b]; i++) apb(1'b0, OFS_INT_STAT, 32'h0, r);
		chk("event bit", 32'h1, {31'h0, r[b]});
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		logic [7:0] ofs [5] = '{OFS_CTRL, OFS_STATUS, OFS_INT_STAT, OFS_INT_MASK, OFS_LIVE};
		foreach (ofs[i]) begin
			apb(1'b0, ofs[i], 32'h0, d);
			chk("reset value", 32'h0, d);
		end
		chk("released line", 32'h0, {31'h0, sdo_oe});
		apb(1'b0, 8'h20, 32'h0, d);
		chk("unmapped error", 32'h1, {31'h0, last_err});
		$display("test reset done");
	endtask

	// stage values, wait one conversion, check live word and interrupt path
	task automatic t_stage;
		apb(1'b1, OFS_TC_DATA, 32'h0064, d);
		apb(1'b1, OFS_REF_DATA, 32'h0190, d);
		apb(1'b1, OFS_FAULT, 32'h5, d);
		apb(1'b1, OFS_INT_MASK, 32'h4, d);
		apb(1'b1, OFS_CTRL, 32'h1, d);
		wait_stat(INT_UPD);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, OFS_CTRL, 32'h0, d);
		apb(1'b0, OFS_LIVE, 32'h0, d);
		chk("live word", fexp(14'h0064, 12'h190, 3'h5), d);
		apb(1'b1, OFS_INT_MASK, 32'h0, d);
		@(negedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_INT_STAT, 32'h7, d);
		apb(1'b0, OFS_INT_STAT, 32'h0, d);
		chk("events cleared", 32'h0, d);
		$display("test stage done");
	endtask

	// full frame while new data is staged: old data must go out, new after select high
	task automatic t_frame;
		logic [31:0] w;
		fork
			host_u.read_frame(32, w);
			begin
				repeat (12) @(posedge pclk);
				apb(1'b1, OFS_TC_DATA, 32'h3ffc, d);
				apb(1'b1, OFS_REF_DATA, 32'h0fff, d);
				apb(1'b1, OFS_FAULT, 32'h2, d);
				apb(1'b1, OFS_CTRL, 32'h1, d);
			end
		join
		chk("frame held", fexp(14'h0064, 12'h190, 3'h5), w);
		chk("released line", 32'h0, {31'h0, sdo_oe});
		apb(1'b0, OFS_INT_STAT, 32'h0, d);
		chk("frame done", 32'h1, d & 32'h3);
		wait_stat(INT_UPD);
		apb(1'b1, OFS_CTRL, 32'h0, d);
		host_u.read_frame(32, w);
		chk("frame fresh", fexp(14'h3ffc, 12'hfff, 3'h2), w);
		apb(1'b1, OFS_INT_STAT, 32'h7, d);
		$display("test frame done");
	endtask

	// short read of the thermocouple field only
	task automatic t_abort;
		logic [31:0] w;
		apb(1'b1, OFS_INT_MASK, 32'h2, d);
		host_u.read_frame(14, w);
		chk("short read", 32'h3ffc, w);
		chk("irq on cut", 32'h1, {31'h0, irq});
		apb(1'b0, OFS_STATUS, 32'h0, d);
		chk("bit count", 32'd14 << STAT_CNT_LSB, d);
		apb(1'b0, OFS_INT_STAT, 32'h0, d);
		chk("frame cut", 32'h2, d & 32'h3);
		apb(1'b1, OFS_INT_MASK, 32'h0, d);
		$display("test abort done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_stage();
		t_frame();
		t_abort();
		end_sim();
	end

	initial begin
		#2_000_000;
		err_count++;
		end_sim();
	end
endmodule
